// *** design/reset_init_sequencer.v ***
// reset initialization sequencer top
`timescale 1ns/1ns
`include "reset_seq_defs.vh"
module reset_init_sequencer #(
   parameter PLL_LOCK_CYCLES = `PLL_LOCK_CYCLES,
   parameter DLL_CYCLES = `DLL_MIN_CYCLES,
   parameter DIV_HOST0 = 0,
   parameter DIV_HOST1 = 1
) (
   input wire mclk,
   input wire sys_rst,
   input wire agentMode,
   input wire power_on_reset_in,
   input wire hard_reset_line_in,
   output wire hard_reset_line_out,
   output wire hard_reset_line_oe,
   input wire soft_reset_line_in,
   output wire soft_reset_line_out,
   output wire soft_reset_line_oe,
   input wire [`BOOT_W-1:0] bootSourceIn,
   input wire input_clock_division_select,
   output wire strapDriveEn,
   input wire pllLocked,
   output reg [`BOOT_W-1:0] bootSource_r,
   output reg clkDivSel_r,
   output reg coreReset_r,
   output reg primarySelAgent_r
);
   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   reg [1:0] porS_r;
   reg [1:0] hardS_r;
   reg [1:0] softS_r;
   reg [1:0] pllS_r;
   reg [1:0] agS_r;
   reg [`BOOT_W:0] strapA_r, strapB_r;
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         porS_r <= 2'h0;
         hardS_r <= 2'h3;
         softS_r <= 2'h3;
         pllS_r <= 2'h0;
         agS_r <= 2'h0;
         strapA_r <= 4'h0;
         strapB_r <= 4'h0;
      end else begin
         porS_r <= {porS_r[0], power_on_reset_in};
         hardS_r <= {hardS_r[0], hard_reset_line_in};
         softS_r <= {softS_r[0], soft_reset_line_in};
         pllS_r <= {pllS_r[0], pllLocked};
         agS_r <= {agS_r[0], agentMode};
         strapA_r <= {input_clock_division_select, bootSourceIn};
         strapB_r <= strapA_r;
      end
   end
   wire por = porS_r[1];
   wire hardLow = ~hardS_r[1];
   wire softLow = ~softS_r[1];
   // ---------------------------------------------------------------
   // bus sync period
   // ---------------------------------------------------------------
   wire tick;
   reg [3:0] divide;
   // division from strap in host mode
   always @* begin
      if (primarySelAgent_r)
         divide = 4'h0;
      else if (clkDivSel_r)
         divide = DIV_HOST1[3:0];
      else
         divide = DIV_HOST0[3:0];
   end
   sync_tick #(.DIV_W(4)) u_tick (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .divide(divide),
      .tick(tick)
   );
   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   reg [2:0] state_r, state_nxt;
   reg [`CNT_W-1:0] cnt_r, cnt_nxt;
   reg [5:0] inCnt_r, inCnt_nxt;
   reg porSeen_r;
   reg strapEn_r, strapEn_nxt;
   reg [`CNT_W-1:0] pllCnt_r;
   wire extReq = (hardLow | softLow) & ~hard_reset_line_oe;
   wire driving = (state_r == `ST_DRIVE) | (state_r == `ST_LAG);
   // true once a full count of sync periods has gone by; the first
   // tick may land at once, so one extra tick is always waited for
   function periodsDone;
      input [`CNT_W-1:0] count;
      input [31:0] limit;
      begin
         periodsDone = (count >= limit);
      end
   endfunction
   // ---------------------------------------------------------------
   // line and strap drive
   // ---------------------------------------------------------------
   // open drain: only low is driven
   assign hard_reset_line_out = 1'b0;
   assign soft_reset_line_out = 1'b0;
   assign hard_reset_line_oe = (state_r == `ST_DRIVE);
   assign soft_reset_line_oe = driving;
   // straps released same cycle as hard line asserts
   assign strapDriveEn = strapEn_r & ~hard_reset_line_oe & ~por;
   always @* begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      inCnt_nxt = inCnt_r;
      strapEn_nxt = strapEn_r;
      // external request qualified by 32 sync periods
      if (state_r == `ST_RUN && extReq) begin
         if (tick && inCnt_r < `REQ_IN_PERIODS)
            inCnt_nxt = inCnt_r + 6'h1;
      end else begin
         inCnt_nxt = 6'h0;
      end
      case (state_r)
         `ST_IDLE: begin
            strapEn_nxt = 1'b0;
            if (porSeen_r && !por) begin
               state_nxt = `ST_DRIVE;
               cnt_nxt = {`CNT_W{1'b0}};
            end
         end
         `ST_DRIVE: begin
            strapEn_nxt = 1'b0;
            if (tick) begin
               if (periodsDone(cnt_r, `DRIVE_PERIODS)) begin
                  state_nxt = `ST_LAG;
                  cnt_nxt = {`CNT_W{1'b0}};
               end else begin
                  cnt_nxt = cnt_r + 1'b1;
               end
            end
         end
         // soft line released 16 periods later
         `ST_LAG: begin
            if (tick) begin
               // strap drive resumes after one period
               if (periodsDone(cnt_r, `STRAP_RESUME_PERIODS))
                  strapEn_nxt = 1'b1;
               if (periodsDone(cnt_r, `SOFT_LAG_PERIODS)) begin
                  state_nxt = `ST_PLL;
                  cnt_nxt = {`CNT_W{1'b0}};
               end else begin
                  cnt_nxt = cnt_r + 1'b1;
               end
            end
         end
         // wait PLL lock or time limit
         // a dead pll must not hang the boot, hence the time limit
         `ST_PLL: begin
            if (pllS_r[1] || pllCnt_r >= PLL_LOCK_CYCLES - 1) begin
               state_nxt = `ST_DLL;
               cnt_nxt = {`CNT_W{1'b0}};
            end
         end
         // DLL lock count in bus clock cycles
         `ST_DLL: begin
            if (cnt_r >= DLL_CYCLES - 1)
               state_nxt = `ST_RUN;
            else
               cnt_nxt = cnt_r + 1'b1;
         end
         `ST_RUN: begin
            if (inCnt_r >= `REQ_IN_PERIODS) begin
               state_nxt = `ST_DRIVE;
               cnt_nxt = {`CNT_W{1'b0}};
            end
         end
         default: state_nxt = `ST_IDLE;
      endcase
      // power-on reset restarts everything
      if (por) begin
         state_nxt = `ST_IDLE;
         strapEn_nxt = 1'b0;
      end
   end
   // ---------------------------------------------------------------
   // state registers
   // ---------------------------------------------------------------
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= `ST_IDLE;
         cnt_r <= {`CNT_W{1'b0}};
         inCnt_r <= 6'h0;
         strapEn_r <= 1'b0;
         porSeen_r <= 1'b0;
         pllCnt_r <= {`CNT_W{1'b0}};
         bootSource_r <= {`BOOT_W{1'b0}};
         clkDivSel_r <= 1'b0;
         primarySelAgent_r <= 1'b0;
         coreReset_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         inCnt_r <= inCnt_nxt;
         strapEn_r <= strapEn_nxt;
         if (por)
            porSeen_r <= 1'b1;
         if (state_r == `ST_PLL)
            pllCnt_r <= pllCnt_r + 1'b1;
         else
            pllCnt_r <= {`CNT_W{1'b0}};
         // straps latched while power-on reset is held
         // boot source, clock division and agent mode
         if (por) begin
            bootSource_r <= strapB_r[`BOOT_W-1:0];
            clkDivSel_r <= strapB_r[`BOOT_W];
            primarySelAgent_r <= agS_r[1];
         end
         coreReset_r <= (state_nxt != `ST_RUN);
      end
   end
   // short power-on pulses rely on the supervisor holding 32
endmodule

// *** design/reset_seq_defs.vh ***
// constants for the reset initialization sequencer
// Operation
// - drive lines low 512 sync periods; release soft 16 after hard
// - stop strap drive within 4 ns of hard assert; resume 1 period after
// - sampled set is three-bit boot source plus clock division bit
// - primary clock from primary input in host, bus clock in agent
// - host mode: sync period follows clock division select strap
// - DLL lock takes 7680 to 122880 bus clock cycles
// - hard and soft lines are open drain, pulled low only
`ifndef RESET_SEQ_DEFS_VH
`define RESET_SEQ_DEFS_VH
`define CLK_PERIOD_NS 10
`define REQ_IN_PERIODS 32
`define DRIVE_PERIODS 512
`define SOFT_LAG_PERIODS 16
`define STRAP_RESUME_PERIODS 1
`define DLL_MIN_CYCLES 7680
`define DLL_MAX_CYCLES 122880
`define PLL_LOCK_US 100
`define PLL_LOCK_CYCLES ((`PLL_LOCK_US * 1000) / `CLK_PERIOD_NS)
`define BOOT_W 3
`define CNT_W 18
`define ST_IDLE 3'h0
`define ST_DRIVE 3'h1
`define ST_LAG 3'h2
`define ST_PLL 3'h3
`define ST_DLL 3'h4
`define ST_RUN 3'h5
`endif

// *** design/sync_tick.v ***
// bus sync period tick generator
`timescale 1ns/1ns
`include "reset_seq_defs.vh"
module sync_tick #(
   parameter DIV_W = 4
) (
   input wire mclk,
   input wire sys_rst,
   input wire [DIV_W-1:0] divide,
   output reg tick
);
   reg [DIV_W-1:0] cnt_r;
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= {DIV_W{1'b0}};
         tick <= 1'b0;
      end else if (cnt_r >= divide) begin
         cnt_r <= {DIV_W{1'b0}};
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule

// *** tb/reset_init_sequencer_properties.sv ***
// port checks for the reset initialization sequencer
`timescale 1ns/1ns
module reset_init_sequencer_properties (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic power_on_reset_in,
   input wire logic hard_reset_line_out,
   input wire logic hard_reset_line_oe,
   input wire logic soft_reset_line_out,
   input wire logic soft_reset_line_oe,
   input wire logic strapDriveEn,
   input wire logic coreReset_r
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // ----------
   // helper and checks
   // ----------
   // saturates at 512 so a long host-mode drive cannot wrap
   logic [10:0] hiCnt_r;
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         hiCnt_r <= 11'h000;
      else if (!hard_reset_line_oe)
         hiCnt_r <= 11'h000;
      else if (hiCnt_r != 11'h200)
         hiCnt_r <= hiCnt_r + 11'h001;
   end
   a_lines_low: assert property (
      hard_reset_line_out == 1'b0 && soft_reset_line_out == 1'b0)
      else $error("line driven high");
   a_hold_min: assert property (
      $fell(hard_reset_line_oe) |-> hiCnt_r == 11'h200)
      else $error("hard drive short");
   a_soft_lag: assert property (
      $fell(hard_reset_line_oe) |-> soft_reset_line_oe [*8])
      else $error("soft released early");
   a_soft_with: assert property (
      hard_reset_line_oe |-> soft_reset_line_oe)
      else $error("soft not with hard");
   a_strap_off: assert property (
      hard_reset_line_oe |-> !strapDriveEn)
      else $error("straps driven in reset");
   a_strap_resume: assert property (
      $fell(hard_reset_line_oe) |-> !strapDriveEn ##1 !strapDriveEn)
      else $error("straps resumed early");
   a_core_held: assert property (
      soft_reset_line_oe |-> coreReset_r)
      else $error("core out of reset");
   a_por_start: assert property (
      $fell(power_on_reset_in) |-> ##[2:5] hard_reset_line_oe)
      else $error("no drive after por");
   cover property ($fell(coreReset_r));
   cover property ($fell(hard_reset_line_oe));
   cover property ($rose(hard_reset_line_oe) && !power_on_reset_in);
endmodule
bind reset_init_sequencer reset_init_sequencer_properties i_chk (.*);

// *** tb/board_model.sv ***
// board model: power-on reset, pll lock and pulled-up reset lines
`timescale 1ns/1ns
module board_model (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic porReq,
   input wire logic extPull,
   input wire logic [7:0] lockDelay,
   input wire logic hardOe,
   input wire logic softOe,
   output logic porOut_r,
   output logic pllLock_r,
   output wire logic hardLine,
   output wire logic softLine
);
   logic [7:0] porCnt_r;
   logic [7:0] lockCnt_r;
   // pull-ups, any party may only pull low
   assign hardLine = ~(hardOe | extPull);
   assign softLine = ~softOe;
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         porOut_r <= 1'b1;
         porCnt_r <= 8'h00;
      // held 40 cycles with straps already stable
      end else if (porReq) begin
         porOut_r <= 1'b1;
         porCnt_r <= 8'h28;
      end else if (porCnt_r != 8'h00) begin
         porCnt_r <= porCnt_r - 8'h01;
         porOut_r <= porCnt_r != 8'h01;
      end
   end
   // lock comes a chosen delay after power-on release
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst || porOut_r) begin
         lockCnt_r <= 8'h00;
         pllLock_r <= 1'b0;
      end else if (lockCnt_r != lockDelay)
         lockCnt_r <= lockCnt_r + 8'h01;
      else
         pllLock_r <= 1'b1;
   end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the reset initialization sequencer
`timescale 1ns/1ns
module tb_top;
   logic mclk = 0, sysRst = 1, porReq = 0, agentMode = 0, extPull = 0;
   logic [3:0] straps = 4'h0;
   logic [7:0] lockDelay = 8'h00;
   logic [31:0] seed = 32'hA5B1, r;
   int fail_count = 0, total_checks = 0, cyc = 0, hi, lag, per;
   wire por, hardLine, softLine, pll, hOe, sOe, sDrv, divR, cr, sel;
   wire [2:0] bootR;
   always #5 mclk = ~mclk;
   board_model i_board (.mclk(mclk), .sys_rst(sysRst), .porReq(porReq),
      .extPull(extPull), .lockDelay(lockDelay), .hardOe(hOe), .softOe(sOe),
      .porOut_r(por), .pllLock_r(pll), .hardLine(hardLine),
      .softLine(softLine));
   reset_init_sequencer #(.PLL_LOCK_CYCLES(300), .DLL_CYCLES(20)) i_dut (
      .mclk(mclk), .sys_rst(sysRst), .agentMode(agentMode),
      .power_on_reset_in(por), .hard_reset_line_in(hardLine),
      .hard_reset_line_out(), .hard_reset_line_oe(hOe),
      .soft_reset_line_in(softLine), .soft_reset_line_out(),
      .soft_reset_line_oe(sOe), .bootSourceIn(straps[2:0]),
      .input_clock_division_select(straps[3]), .strapDriveEn(sDrv),
      .pllLocked(pll), .bootSource_r(bootR), .clkDivSel_r(divR),
      .coreReset_r(cr), .primarySelAgent_r(sel));
   // ----------
   // helpers
   // ----------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk_eq(logic [31:0] got, logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic chk_ge(int got, int lim);
      total_checks++;
      if (got < lim) begin
         fail_count++;
         $display("mismatch t=%0t got %0h min %0h", $time, got, lim);
      end
   endtask
   // counts drive lengths in mclk cycles, sampled on the quiet edge
   task automatic run_seq();
      hi = 0;
      lag = 0;
      while (hOe !== 1'b1) @(negedge mclk);
      while (hOe === 1'b1) begin
         @(negedge mclk);
         hi++;
      end
      while (sOe === 1'b1) begin
         @(negedge mclk);
         lag++;
      end
      while (cr !== 1'b0) @(negedge mclk);
      chk_ge(hi, 512 * per);
      chk_ge(lag, 16 * per);
      chk_eq(sDrv, 1'b1);
      chk_eq({bootR, divR}, {straps[2:0], straps[3]});
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         final_report();
      end
   end
   // ----------
   // main sequence
   // ----------
   initial begin
      repeat (12) @(posedge mclk);
      sysRst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         r = rnd();
         // corner cases first: all straps set in host, then agent
         straps <= (i < 2) ? 4'hF : r[3:0];
         agentMode <= (i < 2) ? i[0] : r[4];
         lockDelay <= r[15:8];
         @(posedge mclk);
         porReq <= 1'b1;
         @(posedge mclk);
         porReq <= 1'b0;
         // host tick follows the division strap
         per = (!agentMode && straps[3]) ? 2 : 1;
         run_seq();
         chk_eq(sel, agentMode);
         if (i[0]) begin
            // a pull shorter than 32 periods is ignored
            extPull <= 1'b1;
            repeat (20 * per) @(posedge mclk);
            extPull <= 1'b0;
            repeat (8 * per) @(posedge mclk);
            chk_eq(cr, 1'b0);
            // outside request held 40 sync periods
            extPull <= 1'b1;
            fork
               run_seq();
               begin
                  repeat (40 * per) @(posedge mclk);
                  extPull <= 1'b0;
               end
            join
         end
         $display("test %0d done", i);
      end
      final_report();
   end
endmodule
